/* File: mfs_pkg.sv */
package mfs_pkg;

    // ****************************************************************
    // Clock and times
    // ****************************************************************
    localparam int CLK_MHZ = 250;
    localparam int OCP_FILTER_NS = 2000;     // Overcurrent filter time
    localparam int RETRY_WAIT_US = 4000;     // Retry wait time
    localparam int SLEEP_ENTRY_US = 120;     // Sleep entry time
    localparam int WAKE_US = 1000;           // Wake time
    localparam int PULSE_MIN_US = 20;        // Reset pulse lower bound
    localparam int PULSE_MAX_US = 40;        // Reset pulse upper bound

    // Least times round up, nothing below one cycle
    localparam int OCP_FILTER_CYC = (OCP_FILTER_NS * CLK_MHZ + 999) / 1000;
    localparam int RETRY_WAIT_CYC = RETRY_WAIT_US * CLK_MHZ;
    localparam int SLEEP_ENTRY_CYC = SLEEP_ENTRY_US * CLK_MHZ;
    localparam int WAKE_CYC = WAKE_US * CLK_MHZ;
    localparam int PULSE_MIN_CYC = PULSE_MIN_US * CLK_MHZ + 1;
    localparam int PULSE_MAX_CYC = PULSE_MAX_US * CLK_MHZ;

    localparam int CNT_W = 24;

    // ****************************************************************
    // Register bus map
    // ****************************************************************
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STAT = 8'h04;
    localparam logic [7:0] REG_FLTS = 8'h08;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

    // Enable pin levels
    typedef enum logic [1:0] {EN_LOW, EN_HIGH, EN_HIZ} mfs_en_t;

    // Power modes
    typedef enum logic [2:0] {
        M_SLEEP, M_WAKE, M_ACTIVE, M_DISABLED
    } mfs_mode_t;

endpackage : mfs_pkg

/* File: mfs_tmr_if.sv */
interface mfs_tmr_if;
    logic        start;
    logic        run;
    logic [23:0] load;
    logic        done;
    logic [23:0] elapsed;
    modport ctl (output start, output run, output load, input done, input elapsed);
    modport tmr (input start, input run, input load, output done, output elapsed);
endinterface : mfs_tmr_if

/* File: mfs_timer.sv */
// Down counter: start loads, run decrements, done at zero; elapsed counts up
module mfs_timer (
    input  wire logic CORE_CLK,
    input  wire logic SRST,
    mfs_tmr_if.tmr    t
);
    import mfs_pkg::*;

    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] el_q;

    // ****************************************************************
    // Counter
    // ****************************************************************
    always_ff @(posedge CORE_CLK) begin
        if (SRST) begin
            cnt_q <= '0;
            el_q  <= '0;
        end else if (t.start) begin
            cnt_q <= t.load;
            el_q  <= '0;
        end else if (t.run && cnt_q != '0) begin
            cnt_q <= cnt_q - 1'b1;
            el_q  <= el_q + 1'b1;
        end
    end

    assign t.done    = (cnt_q == '0);
    assign t.elapsed = el_q;
endmodule : mfs_timer

/* File: mfs_supervisor.sv */
// ****************************************************************
// Fault and mode supervisor
// ****************************************************************
// Functional notes
// - Supply undervoltage: outputs off, fault, pump off
// - Supply undervoltage recovers by itself
// - Pump undervoltage: outputs off, pump runs, auto
// - Overcurrent past filter: bridges off, fault
// - Enable level picks latched or retry live
// - Latched overcurrent waits for sleep pulse
// - Retry after wait and condition gone
// - Thermal trip: bridges, pump off, fault
// - Latched thermal needs cool and pulse
// - Auto thermal resumes when cooled
// - Fault pin open-drain, released at power-up
// - Sleep after entry time, bridges, pump off
// - Raising sleep pin wakes; wait wake time
// - Sleep disables logic regulator
// - Enable low: drivers high impedance
// - Active mode after wake time
// - 20 to 40 us low pulse clears
// - 40 to 120 us clears, sleep uncertain
// - Clearing pulse leaves other blocks alone
//
// Register access over Wishbone and the address map are this design's own decisions.
module mfs_supervisor #(
    parameter int OCP_CYC   = mfs_pkg::OCP_FILTER_CYC,
    parameter int RETRY_CYC = mfs_pkg::RETRY_WAIT_CYC,
    parameter int SLEEP_CYC = mfs_pkg::SLEEP_ENTRY_CYC,
    parameter int WAKE_CYCP = mfs_pkg::WAKE_CYC,
    parameter int PMIN_CYC  = mfs_pkg::PULSE_MIN_CYC,
    parameter int PMAX_CYC  = mfs_pkg::PULSE_MAX_CYC
) (
    input  wire logic         CORE_CLK,
    input  wire logic         SRST,
    input  wire logic         SLEEP_IN_LOW,
    input  wire logic [1:0]   ENABLE_LEVEL,
    input  wire logic         SUPPLY_UNDERVOLTAGE,
    input  wire logic         PUMP_UNDERVOLTAGE,
    input  wire logic         OVERCURRENT_TRIP,
    input  wire logic         THERMAL_TRIP,
    input  wire logic         WB_CYC_I,
    input  wire logic         WB_STB_I,
    input  wire logic         WB_WE_I,
    input  wire logic [7:0]   WB_ADR_I,
    input  wire logic [3:0]   WB_SEL_I,
    input  wire logic [31:0]  WB_DAT_I,
    output logic [31:0]       WB_DAT_O,
    output logic              WB_ACK_O,
    output logic              FAULT_OUT_LOW_O,
    output logic              FAULT_OUT_LOW_OE,
    output logic              BRIDGE_ENABLE,
    output logic              BRIDGE_HIZ,
    output logic              PUMP_ENABLE,
    output logic              REGULATOR_ENABLE,
    output logic              INDEXER_RESET,
    output logic              INPUTS_READY
);
    import mfs_pkg::*;

    initial begin
        if (PMIN_CYC < 1 || PMAX_CYC <= PMIN_CYC || SLEEP_CYC <= PMAX_CYC)
            $error("pulse window parameters out of order");
        if (RETRY_CYC >= 2**CNT_W || WAKE_CYCP >= 2**CNT_W || OCP_CYC < 1)
            $error("timer counts do not fit");
    end

    // ****************************************************************
    // Timers
    // ****************************************************************
    mfs_tmr_if ocp_t ();
    mfs_tmr_if rty_t ();
    mfs_tmr_if slp_t ();
    mfs_tmr_if wak_t ();

    mfs_timer u_ocp (.CORE_CLK(CORE_CLK), .SRST(SRST), .t(ocp_t));
    mfs_timer u_rty (.CORE_CLK(CORE_CLK), .SRST(SRST), .t(rty_t));
    mfs_timer u_slp (.CORE_CLK(CORE_CLK), .SRST(SRST), .t(slp_t));
    mfs_timer u_wak (.CORE_CLK(CORE_CLK), .SRST(SRST), .t(wak_t));

    // ****************************************************************
    // State
    // ****************************************************************
    mfs_mode_t        mode_q;
    mfs_mode_t        mode_d;
    logic             sleep_q;
    logic             ocp_lat_q;
    logic             ocp_lat_d;
    logic             ocp_rty_q;
    logic             ocp_rty_d;
    logic             tsd_lat_q;
    logic             tsd_lat_d;
    logic [31:0]      ctrl_q;
    logic [7:0]       clr_cnt_q;
    logic [2:0]       last_pulse_q;

    // Mode, latch and clear-count reset: pin reset or supply undervoltage
    wire logic logic_rst = SRST | SUPPLY_UNDERVOLTAGE;

    // Sleep pin edges; low length read from the sleep timer
    wire logic sleep_fall = !SLEEP_IN_LOW && sleep_q;
    wire logic sleep_rise = SLEEP_IN_LOW && !sleep_q;
    // Timer is only trusted once the fall has loaded it; stale zero after reset
    wire logic sleep_due = !SLEEP_IN_LOW && !sleep_q && slp_t.done;
    wire logic [CNT_W-1:0] low_len = slp_t.elapsed;
    // Any low past the lower bound clears, also beyond 40 us
    wire logic clr_pulse = sleep_rise && (low_len >= CNT_W'(PMIN_CYC));
    wire logic pulse_ok  = clr_pulse && (low_len < CNT_W'(PMAX_CYC));
    // Software clear alongside the pin pulse
    wire logic sw_clr = WB_CYC_I && WB_STB_I && WB_WE_I && WB_ACK_O
                        && (WB_ADR_I == REG_FLTS) && WB_SEL_I[0] && WB_DAT_I[0];
    wire logic fault_clr = clr_pulse || sw_clr;

    wire logic mode_latched = (ENABLE_LEVEL == EN_HIZ);
    wire logic mode_retry   = (ENABLE_LEVEL == EN_HIGH);

    // Overcurrent qualified by the filter timer
    assign ocp_t.start = !OVERCURRENT_TRIP;
    assign ocp_t.run   = OVERCURRENT_TRIP;
    assign ocp_t.load  = CNT_W'(OCP_CYC);
    wire logic ocp_event = OVERCURRENT_TRIP && ocp_t.done;

    // Retry wait restarts on every qualified trip
    assign rty_t.start = ocp_event;
    assign rty_t.run   = 1'b1;
    assign rty_t.load  = CNT_W'(RETRY_CYC);

    // Sleep timer measures low time and entry delay
    assign slp_t.start = sleep_fall;
    assign slp_t.run   = !SLEEP_IN_LOW;
    assign slp_t.load  = CNT_W'(SLEEP_CYC);

    // Wake timer holds inputs off after leaving sleep or disable
    assign wak_t.start = (mode_q != M_WAKE) && (mode_d == M_WAKE);
    assign wak_t.run   = (mode_q == M_WAKE);
    assign wak_t.load  = CNT_W'(WAKE_CYCP);

    // ****************************************************************
    // Fault latches: new trips beat clears in the same cycle
    // ****************************************************************
    always_comb begin
        ocp_lat_d = ocp_lat_q;
        ocp_rty_d = ocp_rty_q;
        tsd_lat_d = tsd_lat_q;
        // Latched overcurrent cleared by pulse or software clear after condition gone, or by retry mode
        if (fault_clr && !OVERCURRENT_TRIP) begin
            ocp_lat_d = 1'b0;
        end
        if (mode_retry) begin
            ocp_lat_d = 1'b0;
        end
        if (ocp_event && mode_latched) begin
            ocp_lat_d = 1'b1;
        end
        // Retry ends when the wait is over and the trip is gone
        if (rty_t.done && !OVERCURRENT_TRIP) begin
            ocp_rty_d = 1'b0;
        end
        if (ocp_event && !mode_latched) begin
            ocp_rty_d = 1'b1;
        end
        if (mode_latched && ocp_rty_q) begin
            ocp_lat_d = 1'b1;
            ocp_rty_d = 1'b0;
        end
        // Thermal latch, cleared by pulse only once cooled
        if (fault_clr && !THERMAL_TRIP) begin
            tsd_lat_d = 1'b0;
        end
        if (!mode_latched) begin
            tsd_lat_d = 1'b0;
        end
        if (THERMAL_TRIP && mode_latched) begin
            tsd_lat_d = 1'b1;
        end
    end

    // Thermal fault lives while hot, or latched afterwards
    wire logic tsd_fault = THERMAL_TRIP || tsd_lat_q;
    wire logic ocp_fault = ocp_lat_q || ocp_rty_q;
    wire logic any_fault = SUPPLY_UNDERVOLTAGE || PUMP_UNDERVOLTAGE
                           || ocp_fault || tsd_fault;

    // ****************************************************************
    // Mode machine
    // ****************************************************************
    // Long lows enter sleep only at the entry time; a 40..120 us low
    // stays awake here, one of the two allowed outcomes.
    always_comb begin
        mode_d = mode_q;
        case (mode_q)
            M_SLEEP: begin
                if (SLEEP_IN_LOW) begin
                    mode_d = M_WAKE;
                end
            end
            M_WAKE: begin
                if (sleep_due) begin
                    mode_d = M_SLEEP;
                end else if (wak_t.done && SLEEP_IN_LOW) begin
                    mode_d = (ENABLE_LEVEL == EN_LOW) ? M_DISABLED : M_ACTIVE;
                end
            end
            M_ACTIVE: begin
                if (sleep_due) begin
                    mode_d = M_SLEEP;
                end else if (ENABLE_LEVEL == EN_LOW) begin
                    mode_d = M_DISABLED;
                end
            end
            M_DISABLED: begin
                if (sleep_due) begin
                    mode_d = M_SLEEP;
                end else if (ENABLE_LEVEL != EN_LOW && SLEEP_IN_LOW) begin
                    mode_d = M_WAKE;
                end
            end
            default: begin
                mode_d = M_SLEEP;
            end
        endcase
    end

    // ****************************************************************
    // State registers
    // ****************************************************************
    always_ff @(posedge CORE_CLK) begin
        if (logic_rst) begin
            mode_q    <= M_SLEEP;
            sleep_q   <= SLEEP_IN_LOW;                         // No false edge at release
            ocp_lat_q <= 1'b0;
            ocp_rty_q <= 1'b0;
            tsd_lat_q <= 1'b0;
        end else begin
            mode_q    <= mode_d;
            sleep_q   <= SLEEP_IN_LOW;
            ocp_lat_q <= ocp_lat_d;
            ocp_rty_q <= ocp_rty_d;
            tsd_lat_q <= tsd_lat_d;
        end
    end

    // ****************************************************************
    // Pin outputs, all registered
    // ****************************************************************
    wire logic awake   = (mode_q != M_SLEEP);
    wire logic drive   = (mode_q == M_ACTIVE) && !any_fault;
    wire logic pump_on = awake && !SUPPLY_UNDERVOLTAGE
                         && !tsd_fault;

    always_ff @(posedge CORE_CLK) begin
        if (SRST) begin
            FAULT_OUT_LOW_O  <= 1'b0;
            FAULT_OUT_LOW_OE <= 1'b0;
            BRIDGE_ENABLE    <= 1'b0;
            BRIDGE_HIZ       <= 1'b1;
            PUMP_ENABLE      <= 1'b0;
            REGULATOR_ENABLE <= 1'b0;
            INDEXER_RESET    <= 1'b1;
            INPUTS_READY     <= 1'b0;
        end else begin
            FAULT_OUT_LOW_O  <= 1'b0;                          // Open drain: only pulls low
            FAULT_OUT_LOW_OE <= any_fault;
            BRIDGE_ENABLE    <= drive;
            BRIDGE_HIZ       <= !drive;
            PUMP_ENABLE      <= pump_on;
            REGULATOR_ENABLE <= awake && !SUPPLY_UNDERVOLTAGE;
            INDEXER_RESET    <= SUPPLY_UNDERVOLTAGE || !awake;
            INPUTS_READY     <= awake && (mode_q != M_WAKE);
        end
    end

    // ****************************************************************
    // Wishbone slave: one wait state, ack one cycle
    // ****************************************************************
    wire logic        wb_req = WB_CYC_I && WB_STB_I && !WB_ACK_O;
    // Writes land at the edge where the master samples ack high
    wire logic        wb_wr_ctrl = WB_CYC_I && WB_STB_I && WB_ACK_O && WB_WE_I
                                   && (WB_ADR_I == REG_CTRL);
    wire logic [31:0] stat_word = {21'h0, mode_q, pulse_ok, tsd_lat_q,
                                   ocp_rty_q, ocp_lat_q, THERMAL_TRIP,
                                   PUMP_UNDERVOLTAGE, SUPPLY_UNDERVOLTAGE, any_fault};
    logic [31:0]      rd_word;

    // Decode for read data; unmapped reads return zero
    always_comb begin
        if (WB_ADR_I == REG_CTRL) begin
            rd_word = ctrl_q;
        end else if (WB_ADR_I == REG_STAT) begin
            rd_word = stat_word;
        end else if (WB_ADR_I == REG_FLTS) begin
            rd_word = {21'h0, last_pulse_q, clr_cnt_q};
        end else begin
            rd_word = 32'h0;
        end
    end

    // Byte-lane writes to the scratch control word
    always_ff @(posedge CORE_CLK) begin
        if (SRST) begin
            WB_ACK_O <= 1'b0;
            WB_DAT_O <= 32'h0;
            ctrl_q   <= CTRL_RESET;
        end else begin
            WB_ACK_O <= wb_req;
            WB_DAT_O <= wb_req ? rd_word : 32'h0;
            for (int b = 0; b < 4; b++) begin
                if (wb_wr_ctrl && WB_SEL_I[b]) begin
                    ctrl_q[b*8 +: 8] <= WB_DAT_I[b*8 +: 8];
                end
            end
        end
    end

    // Count of fault clears, for software bookkeeping
    always_ff @(posedge CORE_CLK) begin
        if (logic_rst) begin
            clr_cnt_q    <= 8'h00;
            last_pulse_q <= 3'h0;
        end else if (fault_clr) begin
            clr_cnt_q    <= clr_cnt_q + 8'h01;
            last_pulse_q <= {sw_clr, pulse_ok, clr_pulse};
        end
    end

endmodule : mfs_supervisor

/* File: mfs_supervisor_properties.sv */
module mfs_supervisor_properties
    import mfs_pkg::*;
#(
    parameter int OCP_CYC   = 3,
    parameter int SLEEP_CYC = 40,
    parameter int WAKE_CYCP = 20
) (
    input wire logic       CORE_CLK,
    input wire logic       SRST,
    input wire logic       SLEEP_IN_LOW,
    input wire logic [1:0] ENABLE_LEVEL,
    input wire logic       SUPPLY_UNDERVOLTAGE,
    input wire logic       PUMP_UNDERVOLTAGE,
    input wire logic       OVERCURRENT_TRIP,
    input wire logic       THERMAL_TRIP,
    input wire logic       FAULT_OUT_LOW_O,
    input wire logic       FAULT_OUT_LOW_OE,
    input wire logic       BRIDGE_ENABLE,
    input wire logic       BRIDGE_HIZ,
    input wire logic       PUMP_ENABLE,
    input wire logic       REGULATOR_ENABLE,
    input wire logic       INDEXER_RESET,
    input wire logic       INPUTS_READY
);
    // ****************************************************************
    // Run-length counters
    // ****************************************************************
    int lo_q;
    int hi_q;
    int oc_q;
    // Saturate so that long runs never wrap
    always_ff @(posedge CORE_CLK) begin
        lo_q <= (SRST || SLEEP_IN_LOW) ? 0 : lo_q + int'(lo_q < 9999);
        hi_q <= (SRST || !SLEEP_IN_LOW) ? 0 : hi_q + int'(hi_q < 9999);
        oc_q <= (SRST || !OVERCURRENT_TRIP) ? 0 : oc_q + int'(oc_q < 9999);
    end

    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (SRST);

    // ****************************************************************
    // Properties
    // ****************************************************************
    fault_drain_a: assert property (FAULT_OUT_LOW_O == 1'b0)
        else $error("fault pin data not low");
    fault_release_a: assert property ($fell(SRST) |-> !FAULT_OUT_LOW_OE)
        else $error("fault pin pulled after reset");
    supply_uv_a: assert property (SUPPLY_UNDERVOLTAGE |=> FAULT_OUT_LOW_OE && !BRIDGE_ENABLE
        && !PUMP_ENABLE && INDEXER_RESET) else $error("supply undervoltage not obeyed");
    pump_uv_a: assert property (PUMP_UNDERVOLTAGE |=> FAULT_OUT_LOW_OE && !BRIDGE_ENABLE)
        else $error("pump undervoltage not obeyed");
    thermal_off_a: assert property (THERMAL_TRIP |=> FAULT_OUT_LOW_OE && !BRIDGE_ENABLE
        && !PUMP_ENABLE) else $error("thermal trip not obeyed");
    oc_filter_a: assert property (oc_q > OCP_CYC + 1 |-> FAULT_OUT_LOW_OE && !BRIDGE_ENABLE)
        else $error("overcurrent past filter not tripped");
    disable_hiz_a: assert property (ENABLE_LEVEL == EN_LOW ##1 ENABLE_LEVEL == EN_LOW
        |=> BRIDGE_HIZ && !BRIDGE_ENABLE) else $error("bridge driven while disabled");
    sleep_entry_a: assert property (lo_q > SLEEP_CYC + 2 |-> !PUMP_ENABLE
        && !REGULATOR_ENABLE && !BRIDGE_ENABLE) else $error("sleep not entered");
    wake_time_a: assert property ($rose(INPUTS_READY) |-> hi_q >= WAKE_CYCP)
        else $error("inputs ready before wake time");

    cover property ($rose(FAULT_OUT_LOW_OE));
    cover property ($rose(INPUTS_READY));
    cover property (oc_q > OCP_CYC + 1);
endmodule : mfs_supervisor_properties

bind mfs_supervisor mfs_supervisor_properties #(.OCP_CYC(OCP_CYC), .SLEEP_CYC(SLEEP_CYC),
    .WAKE_CYCP(WAKE_CYCP)) i_props (.CORE_CLK, .SRST, .SLEEP_IN_LOW, .ENABLE_LEVEL,
    .SUPPLY_UNDERVOLTAGE, .PUMP_UNDERVOLTAGE, .OVERCURRENT_TRIP, .THERMAL_TRIP,
    .FAULT_OUT_LOW_O, .FAULT_OUT_LOW_OE, .BRIDGE_ENABLE, .BRIDGE_HIZ, .PUMP_ENABLE,
    .REGULATOR_ENABLE, .INDEXER_RESET, .INPUTS_READY);

/* File: mfs_ctrl_model.sv */
module mfs_ctrl_model
    import mfs_pkg::*;
(
    input  wire logic       clk,
    output logic            sleep_in_low,
    output logic [1:0]      enable_level
);
    timeunit 1ns;
    timeprecision 1ps;
    // Asleep with enable high until told otherwise
    initial begin
        sleep_in_low = 1'b0;
        enable_level = EN_HIGH;
    end
    // Pins change only just after an edge
    task automatic set_pins(input logic s, input logic [1:0] e);
        @(posedge clk);
        sleep_in_low <= s;
        enable_level <= e;
    endtask : set_pins
    // Low for n edges; kept inside the clearing window, longer risks sleep
    task automatic clear_pulse(input int n);
        set_pins(1'b0, enable_level);
        repeat (n - 1) @(posedge clk);
        set_pins(1'b1, enable_level);
    endtask : clear_pulse
endmodule : mfs_ctrl_model

/* File: tb_top.sv */
module tb_top;
    import mfs_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int OCP_T = 3;
    localparam int RETRY_T = 50;
    localparam int SLEEP_T = 40;
    localparam int WAKE_T = 20;
    localparam int PMIN_T = 5;
    localparam int PMAX_T = 10;
    logic        core_clk, srst, sleep_pin, uv, puv, oc, ot, cyc, stb, we, ack;
    logic        f_o, f_oe, br, hiz, pump, reg_en, idx_rst, rdy;
    logic [1:0]  en_lvl;
    logic [7:0]  adr;
    logic [31:0] dat, dat_o;
    int          fail_count, checks;

    mfs_ctrl_model i_mfs_ctrl_model (.clk(core_clk), .sleep_in_low(sleep_pin),
        .enable_level(en_lvl));
    mfs_supervisor #(.OCP_CYC(OCP_T), .RETRY_CYC(RETRY_T), .SLEEP_CYC(SLEEP_T),
        .WAKE_CYCP(WAKE_T), .PMIN_CYC(PMIN_T), .PMAX_CYC(PMAX_T)) i_mfs_supervisor (
        .CORE_CLK(core_clk), .SRST(srst), .SLEEP_IN_LOW(sleep_pin), .ENABLE_LEVEL(en_lvl),
        .SUPPLY_UNDERVOLTAGE(uv), .PUMP_UNDERVOLTAGE(puv), .OVERCURRENT_TRIP(oc),
        .THERMAL_TRIP(ot), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr),
        .WB_SEL_I(4'hf), .WB_DAT_I(dat), .WB_DAT_O(dat_o), .WB_ACK_O(ack),
        .FAULT_OUT_LOW_O(f_o), .FAULT_OUT_LOW_OE(f_oe), .BRIDGE_ENABLE(br),
        .BRIDGE_HIZ(hiz), .PUMP_ENABLE(pump), .REGULATOR_ENABLE(reg_en),
        .INDEXER_RESET(idx_rst), .INPUTS_READY(rdy));

    // ****************************************************************
    // Shared tasks
    // ****************************************************************
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic test_done;
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : test_done
    // Classic cycle: hold everything until ack is sampled
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
        @(posedge core_clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        do begin
            @(posedge core_clk);
        end while (ack !== 1'b1);
        q = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : wb
    // Bounded wait for fault pin or bridge to reach a level
    task automatic wt(input bit use_oe, input logic v, output int n);
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while ((use_oe ? f_oe : br) !== v && n < 300);
    endtask : wt

    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end
    // Whole run is a few hundred cycles; the limit is 25000
    initial begin
        #100000;
        fail_count++;
        test_done();
    end

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        int n;
        logic [31:0] q, r;
        {srst, uv, puv, oc, ot, cyc, stb, we, adr, dat} = {1'b1, 47'h0};
        fail_count = 0;
        checks = 0;
        void'($urandom(37));
        repeat (3) @(posedge core_clk);
        srst <= 1'b0;
        @(posedge core_clk);
        chk("fault after reset", 0, f_oe);
        chk("hiz after reset", 1, hiz);
        i_mfs_ctrl_model.set_pins(1'b1, EN_HIGH);
        wt(1'b0, 1'b1, n);
        chk("wake time", 1, n >= WAKE_T && rdy === 1'b1);
        chk("awake pump", 1, pump & reg_en);
        for (int i = 0; i < 4; i++) begin
            r = $urandom;
            wb(1'b1, REG_CTRL, r, q);
            wb(1'b0, REG_CTRL, 32'h0, q);
            chk("ctrl readback", r, q);
        end
        wb(1'b0, 8'h0c, 32'h0, q);
        chk("unmapped read", 0, q);
        // Short trips below the filter must never reach the pin
        repeat (6) begin
            n = 1 + $urandom % 2;
            @(posedge core_clk);
            oc <= 1'b1;
            repeat (n) @(posedge core_clk);
            oc <= 1'b0;
            repeat (3) @(posedge core_clk);
            chk("oc glitch", 0, f_oe);
        end
        for (int i = 0; i < 2; i++) begin
            @(posedge core_clk);
            if (i == 0) uv <= 1'b1; else puv <= 1'b1;
            repeat (3) @(posedge core_clk);
            chk("uv fault", 1, f_oe | br << 1);
            chk("uv pump", i, pump);
            chk("indexer reset", i == 0, idx_rst);
            uv <= 1'b0;
            puv <= 1'b0;
            wt(1'b1, 1'b0, n);
            wt(1'b0, 1'b1, n);
            chk("uv recover", 1, br & !f_oe);
        end
        for (int m = 0; m < 2; m++) begin
            i_mfs_ctrl_model.set_pins(1'b1, m ? EN_HIZ : EN_HIGH);
            @(posedge core_clk);
            ot <= 1'b1;
            repeat (3) @(posedge core_clk);
            chk("thermal fault", 1, f_oe | br << 1 | pump << 2);
            ot <= 1'b0;
            repeat (5) @(posedge core_clk);
            chk("thermal hold", m, f_oe);
            if (m == 1) i_mfs_ctrl_model.clear_pulse(PMIN_T + 2);
            wt(1'b1, 1'b0, n);
            wt(1'b0, 1'b1, n);
            chk("thermal resume", 1, br);
        end
        for (int m = 0; m < 2; m++) begin
            i_mfs_ctrl_model.set_pins(1'b1, m ? EN_HIGH : EN_HIZ);
            @(posedge core_clk);
            oc <= 1'b1;
            repeat (OCP_T + 3) @(posedge core_clk);
            chk("oc fault", 5, f_oe | br << 1 | pump << 2);
            oc <= 1'b0;
            if (m == 0) begin
                repeat (RETRY_T + 10) @(posedge core_clk);
                chk("oc latched", 1, f_oe);
                fork
                    i_mfs_ctrl_model.clear_pulse(PMAX_T - 2);
                    begin
                        repeat (4) @(posedge core_clk);
                        chk("pulse pump", 1, pump);
                    end
                join
            end
            wt(1'b1, 1'b0, n);
            if (m == 1) chk("retry wait", 1, n >= RETRY_T - 2 && n <= RETRY_T + 5);
            wt(1'b0, 1'b1, n);
            chk("oc resume", 1, br);
        end
        i_mfs_ctrl_model.set_pins(1'b1, EN_LOW);
        repeat (3) @(posedge core_clk);
        chk("disable mode", 7, hiz | pump << 1 | reg_en << 2);
        i_mfs_ctrl_model.set_pins(1'b1, EN_HIGH);
        wt(1'b0, 1'b1, n);
        chk("enable wake", 1, n >= WAKE_T);
        i_mfs_ctrl_model.set_pins(1'b0, EN_HIGH);
        repeat (PMAX_T + 5) @(posedge core_clk);
        chk("pre sleep", 1, reg_en);
        repeat (SLEEP_T) @(posedge core_clk);
        chk("asleep", 0, br | pump << 1 | reg_en << 2);
        test_done();
    end
endmodule : tb_top
